// *** hw/fcd_cfg.svh ***
// Purpose: port offsets, field positions and reset values for the transfer register unit
// Assumes: byte-wide I/O ports, offsets are port numbers
// Notes: included by the design
`ifndef FCD_CFG_SVH
`define FCD_CFG_SVH
`define FCD_PORT_CMD_STAT   4'h8
`define FCD_PORT_SWREQ      4'h9
`define FCD_PORT_MASK1      4'ha
`define FCD_PORT_MODE       4'hb
`define FCD_PORT_PTR_CLR    4'hc
`define FCD_PORT_MCLR_TEMP  4'hd
`define FCD_PORT_MASK_CLR   4'he
`define FCD_PORT_MASK_ALL   4'hf
`define FCD_PAGE_CH2        8'h81
`define FCD_PAGE_CH3        8'h82
`define FCD_PAGE_CH01       8'h83
`define FCD_CMD_M2M         0
`define FCD_CMD_HOLD0       1
`define FCD_CMD_DISABLE     2
`define FCD_CMD_COMPRESS    3
`define FCD_CMD_ROTATE      4
`define FCD_CMD_EXTWR       5
`define FCD_CMD_REQ_LOW     6
`define FCD_CMD_ACK_HIGH    7
`define FCD_SEL_BIT         2
`define FCD_MODE_AUTO       4
`define FCD_MODE_DEC        5
`define FCD_CMD_RST         8'h00
`define FCD_MASK_RST        4'hf
`define FCD_MODE_RST        6'h00
`endif

// *** hw/fcd_pkg.sv ***
// Purpose: types shared by the transfer register unit
// Assumes: constants live in fcd_cfg.svh
// Notes: none
package fcd_pkg;
  typedef enum logic [1:0] {
    FCD_XFER_VERIFY = 2'b00,
    FCD_XFER_WRITE  = 2'b01,
    FCD_XFER_READ   = 2'b10,
    FCD_XFER_ILLEGAL = 2'b11
  } fcd_xfer_t;
  typedef enum logic [1:0] {
    FCD_MODE_DEMAND  = 2'b00,
    FCD_MODE_SINGLE  = 2'b01,
    FCD_MODE_BLOCK   = 2'b10,
    FCD_MODE_CASCADE = 2'b11
  } fcd_tmode_t;
  typedef enum logic [1:0] {
    FCD_SVC_IDLE = 2'b00,
    FCD_SVC_ACK  = 2'b01,
    FCD_SVC_DONE = 2'b10
  } fcd_svc_t;
endpackage

// *** hw/fcd_regs.sv ***
// Purpose: four-channel transfer controller register unit with simple channel service
// Assumes: io strobes are one-cycle active-high pulses synchronous to clk
// Notes: each grant performs one transfer step (address step, count down) per service pass
// Notes on behaviour
// - address written low byte at pointer 0, high at 1; reads same order
// - word count two bytes by pointer; writes load base and current
// - channel n address at port 2n, word count at port 2n+1
// - command bit 0 enables memory-to-memory, bit 1 holds channel 0 address
// - command bit 2 set stops servicing of every channel
// - command bit 3 selects compressed timing, ignored in memory-to-memory mode
// - command bit 4 picks fixed or rotating priority
// - command bit 5 picks extended write, don't care when compressed
// - bit 6 sets request polarity, bit 7 sets acknowledge polarity
// - status read gives terminal counts low nibble, requests high nibble
// - port 9 write sets or clears software request of selected channel
// - port A write updates only the selected mask bit from bit 2
// - port B stores selected channel mode, bits 3:2 transfer type
// - mode bit 4 autoinitialize, bit 5 address decrement
// - mode bits 7:6 demand, single, block or cascade
// - any write to port C clears the byte pointer
// - port D write is master clear; read returns temporary register
// - port E write clears all four mask bits
// - port F write loads all masks from bits 3:0
// - write-only page latches give address bits 16 to 19
`timescale 1ns/1ps
`include "fcd_cfg.svh"

module fcd_regs #(
  parameter int NCH = 4
) (
  input  wire logic                clk,
  input  wire logic                rst,
  input  wire logic [7:0]          io_addr,
  input  wire logic [7:0]          io_wdata,
  input  wire logic                io_write_strobe,
  input  wire logic                io_read_strobe,
  output logic      [7:0]          io_rdata,
  input  wire logic [NCH-1:0]      transfer_request_line,
  output logic      [NCH-1:0]      transfer_acknowledge_line,
  output logic      [NCH-1:0]      terminal_count,
  output logic      [19:0]         xfer_addr,
  output logic                     ctrl_m2m_en,
  output logic                     ctrl_hold0,
  output logic                     ctrl_compressed,
  output logic                     ctrl_ext_write,
  output fcd_pkg::fcd_xfer_t       xfer_kind
);
  import fcd_pkg::*;

  logic [15:0] base_addr_q [NCH];
  logic [15:0] cur_addr_q  [NCH];
  logic [15:0] base_cnt_q  [NCH];
  logic [15:0] cur_cnt_q   [NCH];
  logic [5:0]  mode_q      [NCH];
  logic [7:0]  cmd_q;
  logic        ptr_q;
  logic [NCH-1:0] mask_q;
  logic [NCH-1:0] swreq_q;
  logic [NCH-1:0] tc_q;
  logic [7:0]  temp_q;
  logic [3:0]  page2_q;
  logic [3:0]  page3_q;
  logic [3:0]  page01_q;
  logic [1:0]  last_q;
  fcd_svc_t    svc_q;
  logic [1:0]  grant_q;

  logic        dma_sel;
  logic        wr;
  logic        rd;
  logic        chan_port;
  logic [1:0]  port_ch;
  logic        mclr;
  logic [NCH-1:0] req_live;
  logic        any_req;
  logic [1:0]  pick;
  logic [7:0]  rdata_d;
  logic        tc_hit;

  // decode of the low sixteen ports; page latches sit at their own ports
  assign dma_sel   = (io_addr[7:4] == 4'h0);
  assign wr        = io_write_strobe & dma_sel;
  assign rd        = io_read_strobe & dma_sel;
  assign chan_port = ~io_addr[3];
  assign port_ch   = io_addr[2:1];
  assign mclr      = wr & (io_addr[3:0] == `FCD_PORT_MCLR_TEMP);

  // request sense follows the polarity bit; mask gates external and software requests
  assign req_live = ((transfer_request_line ^ {NCH{cmd_q[`FCD_CMD_REQ_LOW]}}) | swreq_q)
                    & ~mask_q;
  assign any_req  = (|req_live) & ~cmd_q[`FCD_CMD_DISABLE];

  // arbiter: fixed starts at channel 0, rotating starts after the last served one
  always_comb
  begin
    logic [1:0] start;
    logic [1:0] idx;
    idx   = 2'd0;
    start = cmd_q[`FCD_CMD_ROTATE] ? last_q + 2'd1 : 2'd0;
    pick  = start;
    for (int k = NCH - 1; k >= 0; k--)
    begin
      idx = start + k[1:0];
      if (req_live[idx])
        pick = idx;
    end
  end

  // terminal count reached when current count wraps below zero on this step
  assign tc_hit = (svc_q == FCD_SVC_ACK) && (cur_cnt_q[grant_q] == 16'h0000);

  // byte pointer: toggles on channel port access, cleared by port C and master clear
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      ptr_q <= 1'b0;
    else if (mclr || (wr && io_addr[3:0] == `FCD_PORT_PTR_CLR))
      ptr_q <= 1'b0;
    else if ((wr || rd) && chan_port)
      ptr_q <= ~ptr_q;
  end

  // per-channel address, count and mode storage plus transfer stepping
  for (genvar c = 0; c < NCH; c++)
  begin : g_ch
    always_ff @(posedge clk or posedge rst)
    begin
      if (rst)
      begin
        base_addr_q[c] <= 16'h0000;
        cur_addr_q[c]  <= 16'h0000;
        base_cnt_q[c]  <= 16'h0000;
        cur_cnt_q[c]   <= 16'h0000;
        mode_q[c]      <= `FCD_MODE_RST;
      end
      else if (wr && chan_port && port_ch == c)
      begin
        if (!io_addr[0])
        begin
          if (!ptr_q)
          begin
            base_addr_q[c][7:0] <= io_wdata;
            cur_addr_q[c][7:0]  <= io_wdata;
          end
          else
          begin
            base_addr_q[c][15:8] <= io_wdata;
            cur_addr_q[c][15:8]  <= io_wdata;
          end
        end
        else if (!ptr_q)
        begin
          base_cnt_q[c][7:0] <= io_wdata;
          cur_cnt_q[c][7:0]  <= io_wdata;
        end
        else
        begin
          base_cnt_q[c][15:8] <= io_wdata;
          cur_cnt_q[c][15:8]  <= io_wdata;
        end
      end
      else if (wr && io_addr[3:0] == `FCD_PORT_MODE && io_wdata[1:0] == c)
        mode_q[c] <= io_wdata[7:2];
      else if (svc_q == FCD_SVC_ACK && grant_q == c)
      begin
        if (tc_hit && mode_q[c][`FCD_MODE_AUTO - 2])
        begin
          cur_addr_q[c] <= base_addr_q[c];
          cur_cnt_q[c]  <= base_cnt_q[c];
        end
        else
        begin
          cur_cnt_q[c] <= cur_cnt_q[c] - 16'd1;
          // channel 0 address held only in memory-to-memory mode
          if (!(c == 0 && cmd_q[`FCD_CMD_M2M] && cmd_q[`FCD_CMD_HOLD0]))
            cur_addr_q[c] <= mode_q[c][`FCD_MODE_DEC - 2] ? cur_addr_q[c] - 16'd1
                                                          : cur_addr_q[c] + 16'd1;
        end
      end
    end
  end

  // command register; master clear returns it to zero
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      cmd_q <= `FCD_CMD_RST;
    else if (mclr)
      cmd_q <= `FCD_CMD_RST;
    else if (wr && io_addr[3:0] == `FCD_PORT_CMD_STAT)
      cmd_q <= io_wdata;
  end

  // mask bits: single, clear-all and write-all forms
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      mask_q <= `FCD_MASK_RST;
    else if (mclr)
      mask_q <= `FCD_MASK_RST;
    else if (wr && io_addr[3:0] == `FCD_PORT_MASK1)
      mask_q[io_wdata[1:0]] <= io_wdata[`FCD_SEL_BIT];
    else if (wr && io_addr[3:0] == `FCD_PORT_MASK_CLR)
      mask_q <= '0;
    else if (wr && io_addr[3:0] == `FCD_PORT_MASK_ALL)
      mask_q <= io_wdata[NCH-1:0];
  end

  // software requests; a finished service drops the served channel's request
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      swreq_q <= '0;
    else if (mclr)
      swreq_q <= '0;
    else if (wr && io_addr[3:0] == `FCD_PORT_SWREQ)
      swreq_q[io_wdata[1:0]] <= io_wdata[`FCD_SEL_BIT];
    else if (svc_q == FCD_SVC_DONE)
      swreq_q[grant_q] <= 1'b0;
  end

  // terminal-count flags: a hit in the same cycle as a status read still sets the flag
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      tc_q <= '0;
    else if (mclr)
      tc_q <= '0;
    else
    begin
      for (int c = 0; c < NCH; c++)
      begin
        if (tc_hit && grant_q == c)
          tc_q[c] <= 1'b1;
        else if (rd && io_addr[3:0] == `FCD_PORT_CMD_STAT)
          tc_q[c] <= 1'b0;
      end
    end
  end

  // temporary register catches the granted channel's current address low byte on each memory-to-memory step
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      temp_q <= 8'h00;
    else if (mclr)
      temp_q <= 8'h00;
    else if (svc_q == FCD_SVC_ACK && cmd_q[`FCD_CMD_M2M])
      temp_q <= cur_addr_q[grant_q][7:0];
  end

  // page latches are write-only and not touched by master clear
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      page2_q  <= 4'h0;
      page3_q  <= 4'h0;
      page01_q <= 4'h0;
    end
    else if (io_write_strobe)
    begin
      if (io_addr == `FCD_PAGE_CH2)
        page2_q <= io_wdata[3:0];
      if (io_addr == `FCD_PAGE_CH3)
        page3_q <= io_wdata[3:0];
      if (io_addr == `FCD_PAGE_CH01)
        page01_q <= io_wdata[3:0];
    end
  end

  // service sequencer: one acknowledge cycle per granted step
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      svc_q   <= FCD_SVC_IDLE;
      grant_q <= 2'd0;
      last_q  <= 2'd3;
    end
    else if (mclr)
      svc_q <= FCD_SVC_IDLE;
    else
    begin
      case (svc_q)
        FCD_SVC_IDLE:
          if (any_req)
          begin
            grant_q <= pick;
            svc_q   <= FCD_SVC_ACK;
          end
        FCD_SVC_ACK:
        begin
          last_q <= grant_q;
          svc_q  <= FCD_SVC_DONE;
        end
        FCD_SVC_DONE:
          svc_q <= FCD_SVC_IDLE;
        default:
          svc_q <= FCD_SVC_IDLE;
      endcase
    end
  end

  // read mux; unmapped and illegal reads return zero
  always_comb
  begin
    rdata_d = 8'h00;
    if (chan_port)
    begin
      if (!io_addr[0])
        rdata_d = ptr_q ? cur_addr_q[port_ch][15:8] : cur_addr_q[port_ch][7:0];
      else
        rdata_d = ptr_q ? cur_cnt_q[port_ch][15:8] : cur_cnt_q[port_ch][7:0];
    end
    else if (io_addr[3:0] == `FCD_PORT_CMD_STAT)
      rdata_d = {req_live, tc_q};
    else if (io_addr[3:0] == `FCD_PORT_MCLR_TEMP)
      rdata_d = temp_q;
  end

  // registered outputs: read data is held one cycle after the strobe
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      io_rdata                  <= 8'h00;
      transfer_acknowledge_line <= '0;
      terminal_count            <= '0;
      xfer_addr                 <= 20'h00000;
      ctrl_m2m_en               <= 1'b0;
      ctrl_hold0                <= 1'b0;
      ctrl_compressed           <= 1'b0;
      ctrl_ext_write            <= 1'b0;
      xfer_kind                 <= FCD_XFER_VERIFY;
    end
    else
    begin
      io_rdata <= rd ? rdata_d : 8'h00;
      for (int c = 0; c < NCH; c++)
        transfer_acknowledge_line[c] <= ((svc_q == FCD_SVC_ACK) && grant_q == c)
                                        ~^ cmd_q[`FCD_CMD_ACK_HIGH];
      terminal_count <= tc_hit ? (NCH'(1) << grant_q) : '0;
      xfer_addr <= {(grant_q == 2'd2) ? page2_q : (grant_q == 2'd3) ? page3_q : page01_q,
                    cur_addr_q[grant_q]};
      ctrl_m2m_en     <= cmd_q[`FCD_CMD_M2M];
      ctrl_hold0      <= cmd_q[`FCD_CMD_HOLD0];
      ctrl_compressed <= cmd_q[`FCD_CMD_COMPRESS] & ~cmd_q[`FCD_CMD_M2M];
      ctrl_ext_write  <= cmd_q[`FCD_CMD_EXTWR] & ~ctrl_compressed_d(cmd_q);
      xfer_kind       <= fcd_xfer_t'(mode_q[grant_q][1:0]);
    end
  end

  function automatic logic ctrl_compressed_d(input logic [7:0] cmd);
    ctrl_compressed_d = cmd[`FCD_CMD_COMPRESS] & ~cmd[`FCD_CMD_M2M];
  endfunction

endmodule // fcd_regs

// *** testbench/fcd_regs_sva.sv ***
// Purpose: port-level checks for the transfer register unit
// Assumes: strobes are one-cycle pulses
// Notes: command and mask shadows are rebuilt from the write traffic
`timescale 1ns/1ps
module fcd_regs_sva #(
  parameter int NCH = 4
) (
  input wire logic           clk,
  input wire logic           rst,
  input wire logic [7:0]     io_addr,
  input wire logic [7:0]     io_wdata,
  input wire logic           io_write_strobe,
  input wire logic           io_read_strobe,
  input wire logic [7:0]     io_rdata,
  input wire logic [NCH-1:0] transfer_acknowledge_line,
  input wire logic [NCH-1:0] terminal_count,
  input wire logic           ctrl_m2m_en,
  input wire logic           ctrl_hold0,
  input wire logic           ctrl_compressed,
  input wire logic           ctrl_ext_write
);
  logic [7:0]     cmd_q;
  logic [NCH-1:0] msk_q;
  logic           live_q;
  logic [2:0]     dis_q;
  logic [NCH-1:0] act;
  // shadow state; live_q skips the edge where ack leaves its reset value
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      cmd_q  <= 8'h00;
      msk_q  <= '1;
      live_q <= 1'b0;
    end
    else
    begin
      live_q <= 1'b1;
      if (io_write_strobe && io_addr == 8'h08)
        cmd_q <= io_wdata;
      if (io_write_strobe && io_addr == 8'h0d)
        cmd_q <= 8'h00;
      if (io_write_strobe && io_addr == 8'h0a)
        msk_q[io_wdata[1:0]] <= io_wdata[2];
      if (io_write_strobe && io_addr == 8'h0e)
        msk_q <= '0;
      if (io_write_strobe && io_addr == 8'h0f)
        msk_q <= io_wdata[NCH-1:0];
      if (io_write_strobe && io_addr == 8'h0d)
        msk_q <= '1;
    end
  end
  // cycles spent disabled with an unchanged command
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      dis_q <= 3'h0;
    else if (!cmd_q[2] || (io_write_strobe && io_addr inside {8'h08, 8'h0d}))
      dis_q <= 3'h0;
    else if (dis_q != 3'h5)
      dis_q <= dis_q + 3'h1;
  end
  assign act = cmd_q[7] ? transfer_acknowledge_line : ~transfer_acknowledge_line;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  AST_ILLEGAL_READ:
  assert property (io_read_strobe && io_addr inside {8'h09, 8'h0a, 8'h0b, 8'h0c, 8'h0e, 8'h0f}
    |=> io_rdata == 8'h00) else $error("illegal port read returned data");
  AST_CMD_DECODE:
  assert property (live_q && cmd_q == $past(cmd_q, 2) |-> ctrl_m2m_en == cmd_q[0]
    && ctrl_hold0 == cmd_q[1]) else $error("command decode mismatch");
  AST_COMPRESS:
  assert property (live_q && cmd_q == $past(cmd_q, 2) |-> ctrl_compressed == (cmd_q[3]
    && !cmd_q[0])) else $error("compressed timing decode mismatch");
  AST_EXT_WRITE:
  assert property (live_q && cmd_q == $past(cmd_q, 2) |-> ctrl_ext_write == (cmd_q[5]
    && !(cmd_q[3] && !cmd_q[0]))) else $error("extended write decode mismatch");
  AST_ACK_ONEHOT:
  assert property (live_q && cmd_q == $past(cmd_q, 2) |-> $onehot0(act))
    else $error("more than one acknowledge active");
  AST_ACK_PULSE:
  assert property (live_q && cmd_q == $past(cmd_q, 2) && act != '0 |=> act == '0)
    else $error("acknowledge held past one cycle");
  AST_DISABLED:
  assert property (dis_q == 3'h5 |-> act == '0) else $error("grant while disabled");
  AST_TC_PULSE:
  assert property (terminal_count != '0 |=> terminal_count == '0)
    else $error("terminal count held past one cycle");
  AST_MASKED:
  assert property (live_q && msk_q == $past(msk_q, 3) && cmd_q == $past(cmd_q, 2)
    |-> (act & msk_q) == '0) else $error("grant on a masked channel");
endmodule // fcd_regs_sva

bind fcd_regs fcd_regs_sva #(.NCH(NCH)) i_sva (
  .clk(clk), .rst(rst), .io_addr(io_addr), .io_wdata(io_wdata),
  .io_write_strobe(io_write_strobe), .io_read_strobe(io_read_strobe), .io_rdata(io_rdata),
  .transfer_acknowledge_line(transfer_acknowledge_line), .terminal_count(terminal_count),
  .ctrl_m2m_en(ctrl_m2m_en), .ctrl_hold0(ctrl_hold0), .ctrl_compressed(ctrl_compressed),
  .ctrl_ext_write(ctrl_ext_write));

// *** testbench/fcd_periph_model.sv ***
// Purpose: peripheral side raising transfer requests
// Assumes: want pulses open a request, terminal count closes it
// Notes: keeps the request until its own count expires, like a real demand source
`timescale 1ns/1ps
module fcd_periph_model #(
  parameter int NCH = 4
) (
  input wire logic            clk,
  input wire logic            rst,
  input wire logic [NCH-1:0]  want,
  input wire logic            req_low,
  input wire logic [NCH-1:0]  terminal_count,
  output logic     [NCH-1:0]  transfer_request_line
);
  logic [NCH-1:0] pend_q;
  // pending requests per channel
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      pend_q <= '0;
    else
      pend_q <= (pend_q | want) & ~terminal_count;
  end
  assign transfer_request_line = req_low ? ~pend_q : pend_q;
endmodule // fcd_periph_model

// *** testbench/fcd_regs_bench.sv ***
// Purpose: self-checking bench for the transfer register unit
// Assumes: one-cycle strobes driven 1 ns after the rising edge
// Notes: service is judged through acknowledge and terminal count pulses
`timescale 1ns/1ps
module fcd_regs_bench;
  import fcd_pkg::*;
  logic        clk, rst, io_write_strobe, io_read_strobe, req_low, cmd7;
  logic [7:0]  io_addr, io_wdata, io_rdata, d;
  logic [3:0]  want, req, ack, tc;
  logic [19:0] xfer_addr;
  logic        m2m, hold, comp, extw;
  fcd_xfer_t   kind;
  logic [15:0] v;
  int          n_errors, n_compared;
  logic [7:0]  bad [6] = '{8'h09, 8'h0a, 8'h0b, 8'h0c, 8'h0e, 8'h0f};
  logic [7:0]  ctab [6] = '{8'h01, 8'h02, 8'h08, 8'h09, 8'h20, 8'h28};
  logic [3:0]  etab [6] = '{4'h8, 4'h4, 4'h2, 4'h8, 4'h1, 4'h2};
  fcd_regs #(.NCH(4)) i_dut (
    .clk(clk), .rst(rst), .io_addr(io_addr), .io_wdata(io_wdata),
    .io_write_strobe(io_write_strobe), .io_read_strobe(io_read_strobe), .io_rdata(io_rdata),
    .transfer_request_line(req), .transfer_acknowledge_line(ack), .terminal_count(tc),
    .xfer_addr(xfer_addr), .ctrl_m2m_en(m2m), .ctrl_hold0(hold), .ctrl_compressed(comp),
    .ctrl_ext_write(extw), .xfer_kind(kind));
  fcd_periph_model #(.NCH(4)) i_periph (
    .clk(clk), .rst(rst), .want(want), .req_low(req_low), .terminal_count(tc),
    .transfer_request_line(req));
  always #4 clk = ~clk;
  task automatic check(input logic [19:0] seen, input logic [19:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic results();
    $display("compared %0d, errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // one strobe per call; the leading edge wait keeps strobes apart
  task automatic wr(input logic [7:0] a, input logic [7:0] b);
    @(posedge clk);
    #1;
    io_addr = a;
    io_wdata = b;
    io_write_strobe = 1'b1;
    @(posedge clk);
    #1;
    io_write_strobe = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] b);
    @(posedge clk);
    #1;
    io_addr = a;
    io_read_strobe = 1'b1;
    @(posedge clk);
    #1;
    io_read_strobe = 1'b0;
    b = io_rdata;
  endtask
  task automatic w16(input logic [7:0] a, input logic [15:0] x);
    wr(a, x[7:0]);
    wr(a, x[15:8]);
  endtask
  task automatic r16(input logic [7:0] a, output logic [15:0] x);
    rd(a, x[7:0]);
    rd(a, x[15:8]);
  endtask
  // raise requests, watch acks, report whether channel ch hit terminal count
  task automatic serve(input int ch, input logic [3:0] w, input logic [3:0] pg,
                       input fcd_xfer_t k, input logic exp);
    logic hit;
    hit = 1'b0;
    want = w;
    for (int i = 0; i < 60 && !hit; i++)
    begin
      @(posedge clk);
      #1;
      want = 4'h0;
      if ((cmd7 ? ack[ch] : ~ack[ch]) === 1'b1)
      begin
        check(xfer_addr[19:16], pg);
        check(kind, k);
      end
      hit = tc[ch];
    end
    check(hit, exp);
    if (exp && !hit)
      results();
  endtask
  initial
  begin
    {clk, io_write_strobe, io_read_strobe, req_low, cmd7} = '0;
    {io_addr, io_wdata, want} = '0;
    rst = 1'b1;
    repeat (2) @(posedge clk);
    #1 rst = 1'b0;
    foreach (bad[i])
    begin
      rd(bad[i], d);
      check(d, 8'h00);
    end
    rd(8'h0d, d);
    check(d, 8'h00);
    wr(8'h00, 8'h77);
    wr(8'h0c, 8'h5a);
    for (int c = 0; c < 4; c++)
    begin
      w16(8'(2 * c), 16'h1234 + 16'(c));
      w16(8'(2 * c + 1), 16'ha0c0 + 16'(c));
    end
    for (int c = 0; c < 4; c++)
    begin
      r16(8'(2 * c), v);
      check(v, 16'h1234 + 16'(c));
      r16(8'(2 * c + 1), v);
      check(v, 16'ha0c0 + 16'(c));
    end
    foreach (ctab[i])
    begin
      wr(8'h08, ctab[i]);
      repeat (2) @(posedge clk);
      check({m2m, hold, comp, extw}, etab[i]);
    end
    // single read transfer on channel 2, two steps
    wr(8'h08, 8'h10);
    w16(8'h05, 16'h0001);
    wr(8'h81, 8'h05);
    wr(8'h0b, 8'h4a);
    wr(8'h0a, 8'h02);
    serve(2, 4'h4, 4'h5, FCD_XFER_READ, 1'b1);
    repeat (2) @(posedge clk);
    rd(8'h08, d);
    check(d, 8'h04);
    rd(8'h08, d);
    check(d, 8'h00);
    // two incrementing steps moved the current address and wrapped the count
    r16(8'h04, v);
    check(v, 16'h1238);
    r16(8'h05, v);
    check(v, 16'hffff);
    // inverted polarities, block write on channel 3
    wr(8'h08, 8'hc0);
    req_low = 1'b1;
    cmd7 = 1'b1;
    w16(8'h07, 16'h0000);
    wr(8'h82, 8'h0a);
    wr(8'h0b, 8'h87);
    wr(8'h0e, 8'h00);
    serve(3, 4'h8, 4'ha, FCD_XFER_WRITE, 1'b1);
    wr(8'h0f, 8'hff);
    wr(8'h0a, 8'h01);
    serve(1, 4'h0, 4'h0, FCD_XFER_VERIFY, 1'b0);
    // software request held off while disabled
    wr(8'h08, 8'h04);
    cmd7 = 1'b0;
    req_low = 1'b0;
    w16(8'h03, 16'h0000);
    wr(8'h83, 8'h03);
    wr(8'h09, 8'h05);
    serve(1, 4'h0, 4'h3, FCD_XFER_VERIFY, 1'b0);
    wr(8'h08, 8'h00);
    serve(1, 4'h0, 4'h3, FCD_XFER_VERIFY, 1'b1);
    // master clear drops command and status, sets every mask
    wr(8'h08, 8'h01);
    wr(8'h0d, 8'h00);
    repeat (2) @(posedge clk);
    check(m2m, 1'b0);
    rd(8'h08, d);
    check(d, 8'h00);
    w16(8'h01, 16'h0000);
    wr(8'h09, 8'h04);
    serve(0, 4'h0, 4'h3, FCD_XFER_VERIFY, 1'b0);
    wr(8'h0a, 8'h00);
    serve(0, 4'h0, 4'h3, FCD_XFER_VERIFY, 1'b1);
    results();
  end
endmodule // fcd_regs_bench
